/* hdl/power_down_mode_control.sv */
`timescale 1ns/10ps
`default_nettype none
module power_down_mode_control
	import power_down_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        manualReset,
	input  wire logic [31:0] regAddr,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [7:0]  regRdData,
	input  wire logic        sleepExec,
	input  wire logic        intAccepted,
	input  wire logic        wakeupAccepted,
	input  wire logic        watchdogOverflow,
	input  wire logic        realtimeStarted,
	input  wire logic        timerFromRealtime,
	input  wire logic        hw_standby_request_pin_n,
	output logic             proc_state_hi,
	output logic             proc_state_lo,
	output logic             wakeup_n,
	output logic             coreRun,
	output logic             pulseGenRun,
	output logic             clockOutRun,
	output logic             memSelfRefresh,
	output logic             realtimeCountRun,
	output logic             timerPinsHold,
	output logic             serialPinsReset,
	output clock_gates_s     gates
);
	// every check below samples on the system clock and rests in reset
	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// pin synchroniser for hardware standby request
	logic hwReqMeta;
	logic hwReqSync;
	always_ff @(posedge clk_sys) begin
		hwReqMeta <= ~hw_standby_request_pin_n;
		hwReqSync <= hwReqMeta;
	end

	// control registers; only power-on reset clears them
	logic [7:0] standby_control;
	logic [7:0] standby_control_second;
	logic [7:0] next_standby_control;
	logic [7:0] next_standby_control_second;
	logic       hitFirst;
	logic       hitSecond;
	assign hitFirst  = regAddr == STANDBY_CONTROL_ADDR;
	assign hitSecond = regAddr == STANDBY_CONTROL_SECOND_ADDR;

	always_comb begin
		next_standby_control        = standby_control;
		next_standby_control_second = standby_control_second;
		if (regWrite && hitFirst) begin
			next_standby_control = regWrData & STANDBY_CONTROL_WMASK; // R10
		end
		if (regWrite && hitSecond) begin
			next_standby_control_second = regWrData;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			standby_control        <= STANDBY_CONTROL_RESET; // R7
			standby_control_second <= STANDBY_CONTROL_SECOND_RESET; // R7
		end else begin
			// manualReset deliberately not used here
			standby_control        <= next_standby_control; // R8
			standby_control_second <= next_standby_control_second; // R8
		end
	end

	// read port; unmapped addresses read zero
	logic [7:0] next_regRdData;
	always_comb begin
		next_regRdData = 8'h00;
		if (regRead && hitFirst) begin
			next_regRdData = standby_control; // R10
		end else if (regRead && hitSecond) begin
			next_regRdData = standby_control_second;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			regRdData <= 8'h00;
		end else begin
			regRdData <= next_regRdData;
		end
	end

	// power-down state machine
	pd_state_e state;
	pd_state_e next_state;
	logic      hwStandby;
	logic      next_hwStandby;
	always_comb begin
		next_state     = state;
		next_hwStandby = hwStandby | hwReqSync; // R20
		unique case (state)
			ST_RUN: begin
				if (sleepExec) begin
					if (standby_control[STANDBY_SELECT_BIT]) begin
						next_state = ST_STANDBY; // R1
					end else begin
						next_state = ST_SLEEP; // R1
					end
				end
			end
			ST_SLEEP: begin
				if (intAccepted) begin
					next_state = ST_RUN; // R16
				end
			end
			ST_STANDBY: begin
				if (wakeupAccepted) begin
					next_state = ST_WAKING; // R6
				end
			end
			ST_WAKING: begin
				if (watchdogOverflow) begin
					next_state = ST_RUN; // R6
				end
			end
		endcase
		if (manualReset) begin
			next_state = ST_RUN; // R16
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state     <= ST_RUN;
			hwStandby <= 1'b0;
		end else begin
			state     <= next_state;
			hwStandby <= next_hwStandby;
		end
	end

	// derived domain controls
	logic inStandby;
	logic inSleep;
	logic periphRun;
	assign inStandby = (state == ST_STANDBY) || (state == ST_WAKING);
	assign inSleep   = state == ST_SLEEP;
	assign periphRun = ~inStandby & ~hwStandby & ~rst; // R2 R15 R17

	always_comb begin
		coreRun          = (state == ST_RUN) & ~hwStandby & ~rst; // R2
		clockOutRun      = ~inStandby & ~hwStandby; // R15 R17
		pulseGenRun      = ~hwStandby &
			(~inStandby | standby_control[CRYSTAL_KEEP_BIT]); // R9 R20
		memSelfRefresh   = inStandby | hwStandby; // R21
		realtimeCountRun = realtimeStarted; // R3 R12
		timerPinsHold    = standby_control[TIMER_STOP_BIT]; // R14
		serialPinsReset  = standby_control[SERIAL_STOP_BIT]; // R14
	end

	// state pins: reset HH, sleep HL, standby LH, run LL
	always_comb begin
		proc_state_hi = rst | manualReset | (inSleep & ~hwStandby); // R5
		proc_state_lo = rst | manualReset | inStandby | hwStandby; // R5
		wakeup_n      = ~(state == ST_WAKING); // R6
	end

	// per-module clock gates
	logic [GATE_COUNT-1:0] stopBits;
	logic [GATE_COUNT-1:0] runBits;
	logic [GATE_COUNT-1:0] gateOut;
	logic                  timerRun;
	assign timerRun = periphRun | (inStandby & ~hwStandby & timerFromRealtime
		& realtimeStarted); // R4
	assign stopBits = {standby_control_second[1:0],
		standby_control_second[2], standby_control_second[3],
		standby_control_second[4], standby_control_second[5],
		standby_control[SERIAL_STOP_BIT], standby_control[REALTIME_STOP_BIT],
		standby_control[TIMER_STOP_BIT]}; // R11 R12 R13 R18
	assign runBits = {{(GATE_COUNT-1){periphRun}}, timerRun};

	genvar gi;
	generate
		for (gi = 0; gi < GATE_COUNT; gi++) begin : g_gate
			module_clock_gate u_gate (
				.clk_sys   (clk_sys),
				.stopBit   (stopBits[gi]),
				.domainRun (runBits[gi]),
				.gateEnable(gateOut[gi])
			);
		end
	endgenerate
	assign gates = clock_gates_s'(gateOut); // R19

	// mode entry on the sleep instruction; a manual reset overrides it
	a_sleep_select: assert property ( // R1
		state == ST_RUN && sleepExec && !manualReset
		&& !standby_control[STANDBY_SELECT_BIT] |=> state == ST_SLEEP)
		else $error("sleep not entered");
	a_standby_select: assert property ( // R1
		state == ST_RUN && sleepExec && !manualReset
		&& standby_control[STANDBY_SELECT_BIT] |=> state == ST_STANDBY)
		else $error("standby not entered");
	a_core_halted: assert property ( // R2
		state != ST_RUN |-> !coreRun)
		else $error("core runs in power-down");

	// leaving sleep: an accepted interrupt, or a manual reset from anywhere
	a_sleep_leave: assert property ( // R16
		inSleep && intAccepted |=> state == ST_RUN)
		else $error("sleep not left on interrupt");
	a_manual_run: assert property ( // R16
		manualReset |=> state == ST_RUN)
		else $error("manual reset did not resume run");

	// processing-state pins in reset, sleep, standby and run
	a_pins_sleep: assert property ( // R5
		inSleep && !hwStandby && !manualReset
		|-> proc_state_hi && !proc_state_lo)
		else $error("bad sleep state pins");
	a_pins_standby: assert property ( // R5
		inStandby && !manualReset |-> !proc_state_hi && proc_state_lo)
		else $error("bad standby state pins");
	a_pins_run: assert property ( // R5
		state == ST_RUN && !hwStandby && !manualReset
		|-> !proc_state_hi && !proc_state_lo)
		else $error("bad run state pins");
	a_pins_reset: assert property ( // R5
		manualReset |-> proc_state_hi && proc_state_lo)
		else $error("bad reset state pins");

	// wakeup pin: low from an accepted wakeup until the watchdog ends it
	sequence s_wake_taken;
		state == ST_STANDBY && wakeupAccepted && !manualReset;
	endsequence
	sequence s_wake_done;
		state == ST_WAKING && watchdogOverflow;
	endsequence
	a_wakeup_low: assert property ( // R6
		s_wake_taken ##1 (!watchdogOverflow && !manualReset)
		|=> !wakeup_n)
		else $error("wakeup not held low");
	a_wakeup_end: assert property ( // R6
		s_wake_done |=> wakeup_n)
		else $error("wakeup still low after watchdog");
	a_wakeup_idle: assert property ( // R6
		state != ST_WAKING |-> wakeup_n)
		else $error("wakeup low outside wakeup phase");

	// register contents across resets and register accesses
	a_por_clear: assert property ( // R7
		$past(rst) |-> standby_control == 8'h00
		&& standby_control_second == 8'h00)
		else $error("register not cleared");
	a_manual_keep: assert property ( // R8
		manualReset && !regWrite |=> $stable(standby_control)
		&& $stable(standby_control_second))
		else $error("manual reset changed register");
	a_reserved_zero: assert property ( // R10
		standby_control[6:5] == 2'b00 && !standby_control[3])
		else $error("reserved bits set");
	a_read_first: assert property ( // R10
		regRead && hitFirst |=> regRdData == $past(standby_control))
		else $error("wrong first register read data");
	a_write_second: assert property ( // R18
		regWrite && hitSecond
		|=> standby_control_second == $past(regWrData))
		else $error("second register write lost");

	// clock generator, clock outputs and memory in each mode
	a_crystal_keep: assert property ( // R9
		inStandby && !hwStandby |-> pulseGenRun
		== standby_control[CRYSTAL_KEEP_BIT])
		else $error("clock generator wrong in standby");
	a_standby_clk: assert property ( // R17
		inStandby ##1 inStandby |-> !gates.serialIface && !clockOutRun)
		else $error("clocks run in standby");
	a_standby_store: assert property ( // R21
		inStandby |-> memSelfRefresh && !coreRun)
		else $error("standby lost memory hold");
	a_sleep_clocks: assert property ( // R15
		inSleep && !hwStandby |-> clockOutRun && pulseGenRun)
		else $error("clocks stopped in sleep");
	a_hw_halt: assert property ( // R20
		hwStandby |-> !coreRun && !pulseGenRun && !clockOutRun)
		else $error("hardware standby left clocks running");
	a_hw_sticky: assert property ( // R20
		hwStandby |=> hwStandby)
		else $error("hardware standby ended without reset");

	// realtime and timer units through standby
	a_rt_count: assert property ( // R3
		inStandby && realtimeStarted |-> realtimeCountRun)
		else $error("realtime count halted in standby");
	a_timer_realtime: assert property ( // R4
		inStandby && !hwStandby && timerFromRealtime && realtimeStarted
		&& !standby_control[TIMER_STOP_BIT] |=> gates.timerUnit)
		else $error("timer halted on realtime input");
	a_timer_halt: assert property ( // R4
		inStandby && !timerFromRealtime |=> !gates.timerUnit)
		else $error("timer runs in standby");

	// module-stop bits and their release
	a_timer_stop: assert property ( // R11
		standby_control[TIMER_STOP_BIT] |=> !gates.timerUnit)
		else $error("timer clock not stopped");
	a_rt_bus_stop: assert property ( // R12
		standby_control[REALTIME_STOP_BIT] |=> !gates.realtimeBus)
		else $error("realtime bus clock not stopped");
	a_serial_stop: assert property ( // R13
		standby_control[SERIAL_STOP_BIT] |=> !gates.serialIface)
		else $error("serial clock not stopped");
	a_break_stop: assert property ( // R18
		standby_control_second[5] |=> !gates.breakUnit)
		else $error("break unit clock not stopped");
	a_gate_restore: assert property ( // R19
		periphRun && !standby_control[SERIAL_STOP_BIT]
		|=> gates.serialIface)
		else $error("serial clock not restored");
endmodule : power_down_mode_control
`default_nettype wire

/* hdl/power_down_pkg.sv */
// Notes on behaviour
// R1: sleep instruction picks sleep or standby
// R2: power-down halts core and some peripherals
// R3: realtime unit counts in standby if started
// R4: timer runs in standby on realtime input
// R5: state pins HH reset HL sleep LH standby
// R6: wakeup low from accepted wakeup until watchdog
// R7: power-on reset clears both control registers
// R8: manual reset keeps both control registers
// R9: crystal-keep bit keeps clock generator in standby
// R10: reserved bits 6,5,3 read zero
// R11: bit 2 stops timer unit clock
// R12: bit 1 stops realtime bus clock only
// R13: bit 0 stops serial interface clock
// R14: stopped timer pins hold, serial pins reset
// R15: sleep keeps peripherals and clock outputs running
// R16: interrupt or reset leaves sleep mode
// R17: standby stops all clocks inside chip; code keeps pulseGenRun with bit 4 and timerUnit on realtime input
// R18: second register bits stop other peripherals
// R19: clearing bit or reset restores clock
// R20: hardware standby halts all until power-on; code keeps realtimeCountRun following realtimeStarted
// R21: standby holds state, memory self-refresh
`default_nettype none
package power_down_pkg;
	localparam logic [31:0] STANDBY_CONTROL_ADDR        = 32'hFFFFFF82;
	localparam logic [31:0] STANDBY_CONTROL_SECOND_ADDR = 32'hFFFFFF88;
	localparam logic [7:0]  STANDBY_CONTROL_RESET       = 8'h00;
	localparam logic [7:0]  STANDBY_CONTROL_SECOND_RESET = 8'h00;
	localparam logic [7:0]  STANDBY_CONTROL_WMASK       = 8'h97;
	localparam int          STANDBY_SELECT_BIT          = 7;
	localparam int          CRYSTAL_KEEP_BIT            = 4;
	localparam int          TIMER_STOP_BIT              = 2;
	localparam int          REALTIME_STOP_BIT           = 1;
	localparam int          SERIAL_STOP_BIT             = 0;
	localparam int          GATE_COUNT                  = 9;

	typedef enum logic [1:0] {
		ST_RUN     = 2'b00,
		ST_SLEEP   = 2'b01,
		ST_STANDBY = 2'b11,
		ST_WAKING  = 2'b10
	} pd_state_e;

	// clock-enable bundle for every gated peripheral
	typedef struct packed {
		logic serialFifo;
		logic infrared;
		logic adc;
		logic dac;
		logic dma;
		logic breakUnit;
		logic serialIface;
		logic realtimeBus;
		logic timerUnit;
	} clock_gates_s;
endpackage : power_down_pkg
`default_nettype wire

/* hdl/module_clock_gate.sv */
`timescale 1ns/10ps
`default_nettype none
module module_clock_gate
	import power_down_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic stopBit,
	input  wire logic domainRun,
	output logic      gateEnable
);
	// gate is a registered enable; stop bit cleared restores supply while domainRun is high
	logic next_gateEnable;
	always_comb begin
		next_gateEnable = domainRun & ~stopBit; // R19
	end
	always_ff @(posedge clk_sys) begin
		gateEnable <= next_gateEnable;
	end
endmodule : module_clock_gate
`default_nettype wire

/* verif/core_stub.sv */
`timescale 1ns/10ps
`default_nettype none
module core_stub (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       coreRun,
	input  wire logic       go,
	input  wire logic [1:0] cmd,
	output logic            sleepExec,
	output logic            intAccepted,
	output logic            wakeupAccepted,
	output logic            watchdogOverflow
);
	// one-cycle event pulses; a halted core executes no sleep instruction
	always_ff @(posedge clk_sys) begin
		sleepExec        <= !rst && go && cmd == 2'h0 && coreRun;
		intAccepted      <= !rst && go && cmd == 2'h1;
		wakeupAccepted   <= !rst && go && cmd == 2'h2;
		watchdogOverflow <= !rst && go && cmd == 2'h3;
	end
endmodule : core_stub
`default_nettype wire

/* verif/power_down_mode_control_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module power_down_mode_control_bench
	import power_down_pkg::*;
;
	logic         clk_sys = 1'b0;
	logic         rst = 1'b1;
	logic         manualReset = 1'b0;
	logic [31:0]  regAddr = 32'h0;
	logic [7:0]   regWrData = 8'h00;
	logic         regWrite = 1'b0;
	logic         regRead = 1'b0;
	logic         rtStart = 1'b0;
	logic         tmrFromRt = 1'b0;
	logic         hwStandbyN = 1'b1;
	logic         go = 1'b0;
	logic [1:0]   cmd = 2'h0;
	logic [7:0]   regRdData;
	logic         sleepExec, intAccepted, wakeupAccepted, watchdogOverflow;
	logic         stHi, stLo, wakeup_n, coreRun, pulseGenRun, clockOutRun;
	logic         memSelfRefresh, realtimeCountRun, timerPinsHold;
	logic         serialPinsReset;
	clock_gates_s gates;
	int           err_total = 0;
	int           check_count = 0;

	// 20 MHz system clock
	always #25 clk_sys = ~clk_sys;

	core_stub core (.clk_sys(clk_sys), .rst(rst), .coreRun(coreRun),
		.go(go), .cmd(cmd), .sleepExec(sleepExec),
		.intAccepted(intAccepted), .wakeupAccepted(wakeupAccepted),
		.watchdogOverflow(watchdogOverflow));

	power_down_mode_control dut (.clk_sys(clk_sys), .rst(rst),
		.manualReset(manualReset), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .sleepExec(sleepExec),
		.intAccepted(intAccepted), .wakeupAccepted(wakeupAccepted),
		.watchdogOverflow(watchdogOverflow), .realtimeStarted(rtStart),
		.timerFromRealtime(tmrFromRt),
		.hw_standby_request_pin_n(hwStandbyN), .proc_state_hi(stHi),
		.proc_state_lo(stLo), .wakeup_n(wakeup_n), .coreRun(coreRun),
		.pulseGenRun(pulseGenRun), .clockOutRun(clockOutRun),
		.memSelfRefresh(memSelfRefresh),
		.realtimeCountRun(realtimeCountRun),
		.timerPinsHold(timerPinsHold), .serialPinsReset(serialPinsReset),
		.gates(gates));

	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// waits n edges and lets their updates settle
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	task automatic wreg(input logic [31:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask : wreg

	// read data stands only in the cycle after the strobe
	task automatic rreg(input logic [31:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1;
		chk(regRdData, e);
	endtask : rreg

	// asks the core model for one event pulse
	task automatic core_ev(input logic [1:0] c);
		@(posedge clk_sys);
		cmd <= c;
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		tick(3);
	endtask : core_ev

	task automatic wrap_up;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	// cuts a hang short
	initial begin
		#2ms;
		err_total++;
		wrap_up();
	end

	initial begin
		tick(1);
		chk({stHi, stLo}, 9'h3);
		@(posedge clk_sys);
		rst <= 1'b0;
		rreg(STANDBY_CONTROL_ADDR, 8'h00);
		rreg(STANDBY_CONTROL_SECOND_ADDR, 8'h00);
		wreg(STANDBY_CONTROL_ADDR, 8'h97);
		rreg(STANDBY_CONTROL_ADDR, 8'h97);
		wreg(STANDBY_CONTROL_SECOND_ADDR, 8'h3F);
		rreg(STANDBY_CONTROL_SECOND_ADDR, 8'h3F);
		rreg(32'hFFFFFF84, 8'h00);
		tick(2);
		chk(gates, 9'h000);
		chk({timerPinsHold, serialPinsReset}, 9'h3);
		@(posedge clk_sys);
		manualReset <= 1'b1;
		tick(2);
		chk({stHi, stLo}, 9'h3);
		@(posedge clk_sys);
		manualReset <= 1'b0;
		rreg(STANDBY_CONTROL_ADDR, 8'h97);
		rreg(STANDBY_CONTROL_SECOND_ADDR, 8'h3F);
		wreg(STANDBY_CONTROL_ADDR, 8'h00);
		wreg(STANDBY_CONTROL_SECOND_ADDR, 8'h00);
		tick(2);
		chk(gates, 9'h1FF);
		core_ev(2'h0);
		chk({stHi, stLo, coreRun}, 9'h4);
		chk({clockOutRun, gates}, 11'h3FF);
		core_ev(2'h1);
		chk({stHi, stLo, coreRun}, 9'h1);
		wreg(STANDBY_CONTROL_ADDR, 8'h90);
		rtStart <= 1'b1;
		tmrFromRt <= 1'b1;
		core_ev(2'h0);
		chk({stHi, stLo, pulseGenRun, memSelfRefresh}, 9'h7);
		chk({clockOutRun, gates}, 9'h001);
		chk(realtimeCountRun, 1'b1);
		core_ev(2'h2);
		chk(wakeup_n, 1'b0);
		core_ev(2'h3);
		chk({stHi, stLo, wakeup_n}, 9'h1);
		wreg(STANDBY_CONTROL_ADDR, 8'h80);
		rtStart <= 1'b0;
		core_ev(2'h0);
		chk({pulseGenRun, gates, realtimeCountRun}, 9'h0);
		core_ev(2'h2);
		core_ev(2'h3);
		@(posedge clk_sys);
		hwStandbyN <= 1'b0;
		tick(5);
		chk({stHi, stLo, coreRun, pulseGenRun}, 9'h4);
		@(posedge clk_sys);
		hwStandbyN <= 1'b1;
		tick(4);
		chk({stHi, stLo, coreRun}, 9'h2);
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		tick(3);
		chk({stHi, stLo, coreRun}, 9'h1);
		rreg(STANDBY_CONTROL_ADDR, 8'h00);
		wrap_up();
	end
endmodule : power_down_mode_control_bench
`default_nettype wire
